/* File: verilog/tpg_consts.svh */
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH
// Widths
`define TPG_ADDR_W 8
`define TPG_CNT_W 16
`define TPG_PRE_W 8
`define TPG_IN_N 4
// Register byte offsets
`define TPG_OFS_RUN 8'h00
`define TPG_OFS_MODE 8'h04
`define TPG_OFS_FLOP 8'h08
`define TPG_OFS_CMPA 8'h0c
`define TPG_OFS_CMPB 8'h10
`define TPG_OFS_CAPA 8'h14
`define TPG_OFS_CAPB 8'h18
`define TPG_OFS_CNT 8'h1c
`define TPG_OFS_STAT 8'h20
// Run register bits
`define TPG_RUN_EN 0
`define TPG_RUN_PRE 2
`define TPG_RUN_DBE 7
// Mode register fields
`define TPG_MOD_CLK_LO 0
`define TPG_MOD_CLK_HI 1
`define TPG_MOD_CPM_LO 2
`define TPG_MOD_CPM_HI 3
`define TPG_MOD_PGM 4
`define TPG_MOD_SWCAP 5
`define TPG_CLK_EVENT 2'h0
`define TPG_CLK_PRE1 2'h1
`define TPG_CLK_PRE2 2'h2
`define TPG_CPM_OFF 2'h0
`define TPG_CPM_TWO_PIN 2'h1
`define TPG_CPM_WIDTH 2'h2
`define TPG_CPM_COMPANION 2'h3
// Flop control register fields
`define TPG_FFC_CMD_LO 0
`define TPG_FFC_CMD_HI 1
`define TPG_FFC_CLEAR 2'h2
`define TPG_FFC_SET 2'h1
`define TPG_FFC_CMD_READ 2'h3
`define TPG_FFC_TGL_A 2
`define TPG_FFC_TGL_B 3
`define TPG_FFC_TGL_CAPA 4
`define TPG_FFC_TGL_CAPB 5
`define TPG_FFC_STATE 6
// Status bits
`define TPG_ST_MATCH_A 0
`define TPG_ST_MATCH_B 1
`define TPG_ST_OVF 2
// Prescaler tap masks (divide by 2, 8, 32)
`define TPG_PRE_MASK1 8'h01
`define TPG_PRE_MASK2 8'h07
`define TPG_PRE_MASK3 8'h1f
// Synchronised input indices
`define TPG_IN_EVENT 0
`define TPG_IN_TRIG_A 1
`define TPG_IN_TRIG_B 2
`define TPG_IN_COMP 3
// Bus answers and constants
`define TPG_RESP_OKAY 2'h0
`define TPG_RESP_SLVERR 2'h2
`define TPG_CNT_MAX 16'hffff
`define TPG_CNT_ZERO 16'h0000
`endif

/* File: verilog/tpg_pkg.sv */
`default_nettype none
`include "tpg_consts.svh"
package tpg_pkg;
  // Complete state of the timer channel and its bus slave
  typedef struct packed {
    logic [`TPG_ADDR_W-1:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic run;
    logic pre_run;
    logic dbe;
    logic [1:0] clk_sel;
    logic [1:0] cap_mode;
    logic pgm;
    logic ten_a;
    logic ten_b;
    logic ten_cap_a;
    logic ten_cap_b;
    logic flop;
    logic [`TPG_CNT_W-1:0] cmp_a;
    logic [`TPG_CNT_W-1:0] cmp_a_buf;
    logic [`TPG_CNT_W-1:0] cmp_b;
    logic [`TPG_CNT_W-1:0] cap_a;
    logic [`TPG_CNT_W-1:0] cap_b;
    logic [`TPG_CNT_W-1:0] cnt;
    logic [`TPG_PRE_W-1:0] pre_cnt;
    logic [2:0] status;
    logic irq_b;
    logic [`TPG_IN_N-1:0] sync1;
    logic [`TPG_IN_N-1:0] sync2;
    logic [`TPG_IN_N-1:0] sync3;
    logic [`TPG_IN_N-1:0] flt;
  } tpg_state_s;
endpackage
`default_nettype wire

/* File: verilog/tpg_timer.sv */
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tpg_consts.svh"

// Operation
// - In pulse mode the output flop toggles on counter match with compare A and B.
// - The output flop state drives the pulse output pin.
// - Pulse polarity follows the flop level loaded before counting.
// - With double-buffering on, compare A writes land in a holding buffer.
// - With double-buffering on, each compare B match loads compare A from buffer.
// - Run register bit 7 enables double-buffering of compare A.
// - Run bit 0 zero stops; run bit and prescaler bit 2 start counting.
// - Both compare registers are 16 bits: A sets duty, B sets period.
// - Flop control holds toggle enables for match B and A; 11 enables both.
// - Flop control command 10 forces the output flop to zero, 01 forces it to one.
// - Counter match with compare B raises the match interrupt request.
// - Flop may toggle when the counter is captured into capture A.
// - In two-pin and pulse-width modes, trigger A rising edge latches the counter into capture A.
// - In pulse-width mode, trigger A falling edge latches into capture B.
// - In time-difference mode, trigger B rising edge latches into capture B.
// - Capture mode 11 uses companion flop: rise to A, fall to B.
// - Mode register can select event input rising edges as counter clock.
// - Mode register can select a prescaler output as free-running clock.
// - Capture mode setting 00 disables all pin capture latching; software capture still loads capture A.
// - Reading the status register clears all its flags.
module tpg_timer
  import tpg_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [`TPG_ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [`TPG_ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic EVENT_IN,
  input wire logic TRIGGER_IN_A,
  input wire logic TRIGGER_IN_B,
  input wire logic COMPANION_TIMER_FLOP,
  output logic PULSE_OUT_PIN,
  output logic MATCH_B_IRQ
);

  // ************************************************************
  // Helpers
  // ************************************************************

  // Byte-lane merge for the 16-bit registers
  function automatic logic [`TPG_CNT_W-1:0] merge16(
    input logic [`TPG_CNT_W-1:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [`TPG_CNT_W-1:0] res;
    res = old;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction

  // Word-aligned view of a byte address
  function automatic logic [`TPG_ADDR_W-1:0] word_of(input logic [`TPG_ADDR_W-1:0] a);
    return {a[`TPG_ADDR_W-1:2], 2'h0};
  endfunction

  // Prescaler tap: one tick each time the selected low bits roll over
  function automatic logic pre_tap(
    input logic [1:0] sel,
    input logic [`TPG_PRE_W-1:0] pc
  );
    logic hit;
    case (sel)
      `TPG_CLK_PRE1: hit = ((pc & `TPG_PRE_MASK1) == `TPG_PRE_MASK1);
      `TPG_CLK_PRE2: hit = ((pc & `TPG_PRE_MASK2) == `TPG_PRE_MASK2);
      default: hit = ((pc & `TPG_PRE_MASK3) == `TPG_PRE_MASK3);
    endcase
    return hit;
  endfunction

  // ************************************************************
  // State
  // ************************************************************

  tpg_state_s st_r;
  tpg_state_s st_nxt;

  logic aw_hs;
  logic w_hs;
  logic wr_do;
  logic rd_do;
  logic [`TPG_ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [`TPG_ADDR_W-1:0] ra;
  logic [31:0] rmux;
  logic rbad;
  logic wbad;
  logic [`TPG_IN_N-1:0] agree;
  logic [`TPG_IN_N-1:0] rise;
  logic [`TPG_IN_N-1:0] fall;
  logic tick;
  logic step;
  logic match_a;
  logic match_b;
  logic ovf;
  logic cap_a_ev;
  logic cap_b_ev;
  logic toggle;
  logic rd_status;

  // Handshake outputs straight from state
  assign AWREADY = !st_r.aw_held && !st_r.bvalid;
  assign WREADY = !st_r.w_held && !st_r.bvalid;
  assign ARREADY = !st_r.rvalid;
  assign BVALID = st_r.bvalid;
  assign BRESP = st_r.bresp;
  assign RVALID = st_r.rvalid;
  assign RDATA = st_r.rdata;
  assign RRESP = st_r.rresp;
  assign PULSE_OUT_PIN = st_r.flop;
  assign MATCH_B_IRQ = st_r.irq_b;

  // ************************************************************
  // Next-state logic
  // ************************************************************

  // Whole channel in one pass; software writes are applied last
  always_comb
  begin
    st_nxt = st_r;

    // Pin synchronisers; a level counts once stages two and three agree
    st_nxt.sync1 = {COMPANION_TIMER_FLOP, TRIGGER_IN_B, TRIGGER_IN_A, EVENT_IN};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    agree = ~(st_r.sync2 ^ st_r.sync3);
    st_nxt.flt = (st_r.sync3 & agree) | (st_r.flt & ~agree);
    rise = st_nxt.flt & ~st_r.flt;
    fall = ~st_nxt.flt & st_r.flt;

    // Bus write side: take address and data in either order
    aw_hs = AWVALID && AWREADY;
    w_hs = WVALID && WREADY;
    wa = st_r.aw_held ? st_r.aw_addr : AWADDR;
    wd = st_r.w_held ? st_r.w_data : WDATA;
    ws = st_r.w_held ? st_r.w_strb : WSTRB;
    wr_do = (st_r.aw_held || aw_hs) && (st_r.w_held || w_hs) && !st_r.bvalid;
    wa = word_of(wa);

    // Bus read side: one outstanding read
    rd_do = ARVALID && !st_r.rvalid;
    ra = word_of(ARADDR);
    rd_status = rd_do && (ra == `TPG_OFS_STAT);

    // Prescaler free-runs while enabled, parked at zero otherwise
    st_nxt.pre_cnt = st_r.pre_run ? st_r.pre_cnt + `TPG_PRE_W'(1) : `TPG_PRE_W'(0);

    // Counter clock source: event pin edges or a prescaler tap
    tick = (st_r.clk_sel == `TPG_CLK_EVENT) ? rise[`TPG_IN_EVENT]
         : pre_tap(st_r.clk_sel, st_r.pre_cnt);
    // Event mode still gated by the prescaler bit, so both must be set
    step = st_r.run && st_r.pre_run && tick;

    // Comparators look at the value being left on this step
    match_a = step && (st_r.cnt == st_r.cmp_a);
    match_b = step && (st_r.cnt == st_r.cmp_b);
    ovf = step && (st_r.cnt == `TPG_CNT_MAX) && !(st_r.pgm && match_b);

    // Up-counter: cleared while stopped, and at the period match in pulse mode
    if (!st_r.run || (st_r.pgm && match_b))
    begin
      st_nxt.cnt = `TPG_CNT_ZERO;
    end
    else if (step)
    begin
      st_nxt.cnt = st_r.cnt + `TPG_CNT_W'(1);
    end

    // Compare A reload from its buffer on every period match while double-buffering is on
    if (match_b && st_r.dbe)
    begin
      st_nxt.cmp_a = st_r.cmp_a_buf;
    end
    st_nxt.irq_b = match_b;

    // Capture triggers
    cap_a_ev = 1'b0;
    cap_b_ev = 1'b0;
    case (st_r.cap_mode)
      `TPG_CPM_OFF: cap_a_ev = 1'b0;
      `TPG_CPM_TWO_PIN:
      begin
        cap_a_ev = rise[`TPG_IN_TRIG_A];
        cap_b_ev = rise[`TPG_IN_TRIG_B];
      end
      `TPG_CPM_WIDTH:
      begin
        cap_a_ev = rise[`TPG_IN_TRIG_A];
        cap_b_ev = fall[`TPG_IN_TRIG_A];
      end
      `TPG_CPM_COMPANION:
      begin
        cap_a_ev = rise[`TPG_IN_COMP];
        cap_b_ev = fall[`TPG_IN_COMP];
      end
      default: cap_b_ev = 1'b0;
    endcase
    // Software capture into capture A, regardless of capture mode
    if (wr_do && wa == `TPG_OFS_MODE && ws[0] && wd[`TPG_MOD_SWCAP])
    begin
      cap_a_ev = 1'b1;
    end
    if (cap_a_ev)
      st_nxt.cap_a = st_r.cnt;
    if (cap_b_ev)
      st_nxt.cap_b = st_r.cnt;

    // Output flop: each enabled event flips it once
    toggle = (match_a && st_r.ten_a) ^ (match_b && st_r.ten_b)
           ^ (cap_a_ev && st_r.ten_cap_a) ^ (cap_b_ev && st_r.ten_cap_b);
    st_nxt.flop = st_r.flop ^ toggle;

    // Status flags: hardware set beats the read-clear
    st_nxt.status = (rd_status ? 3'h0 : st_r.status)
                  | {ovf, match_b, match_a};

    // Register writes
    wbad = 1'b0;
    if (wr_do)
    begin
      case (wa)
        `TPG_OFS_RUN:
        begin
          if (ws[0])
          begin
            st_nxt.run = wd[`TPG_RUN_EN];
            st_nxt.pre_run = wd[`TPG_RUN_PRE];
            st_nxt.dbe = wd[`TPG_RUN_DBE];
          end
        end
        `TPG_OFS_MODE:
        begin
          if (ws[0])
          begin
            st_nxt.clk_sel = wd[`TPG_MOD_CLK_HI:`TPG_MOD_CLK_LO];
            st_nxt.cap_mode = wd[`TPG_MOD_CPM_HI:`TPG_MOD_CPM_LO];
            st_nxt.pgm = wd[`TPG_MOD_PGM];
          end
        end
        `TPG_OFS_FLOP:
        begin
          if (ws[0])
          begin
            st_nxt.ten_a = wd[`TPG_FFC_TGL_A];
            st_nxt.ten_b = wd[`TPG_FFC_TGL_B];
            st_nxt.ten_cap_a = wd[`TPG_FFC_TGL_CAPA];
            st_nxt.ten_cap_b = wd[`TPG_FFC_TGL_CAPB];
            // Initial level sets polarity; command beats a same-cycle toggle
            if (wd[`TPG_FFC_CMD_HI:`TPG_FFC_CMD_LO] == `TPG_FFC_CLEAR)
            begin
              st_nxt.flop = 1'b0;
            end
            else if (wd[`TPG_FFC_CMD_HI:`TPG_FFC_CMD_LO] == `TPG_FFC_SET)
            begin
              st_nxt.flop = 1'b1;
            end
          end
        end
        `TPG_OFS_CMPA:
        begin
          // Buffer always follows the write; active copy only when unbuffered
          st_nxt.cmp_a_buf = merge16(st_r.cmp_a_buf, wd, ws);
          if (!st_r.dbe)
          begin
            st_nxt.cmp_a = merge16(st_r.cmp_a, wd, ws);
          end
        end
        `TPG_OFS_CMPB: st_nxt.cmp_b = merge16(st_r.cmp_b, wd, ws);
        // Read-only words: write ignored, answered OKAY
        `TPG_OFS_CAPA, `TPG_OFS_CAPB, `TPG_OFS_CNT, `TPG_OFS_STAT: wbad = 1'b0;
        default: wbad = 1'b1;
      endcase
    end

    // Write channel bookkeeping
    if (wr_do)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wbad ? `TPG_RESP_SLVERR : `TPG_RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        st_nxt.aw_held = 1'b1;
        st_nxt.aw_addr = AWADDR;
      end
      if (w_hs)
      begin
        st_nxt.w_held = 1'b1;
        st_nxt.w_data = WDATA;
        st_nxt.w_strb = WSTRB;
      end
      if (st_r.bvalid && BREADY)
      begin
        st_nxt.bvalid = 1'b0;
      end
    end

    // Read mux; unmapped words read zero with SLVERR
    rbad = 1'b0;
    rmux = 32'h0;
    case (ra)
      `TPG_OFS_RUN:
      begin
        rmux[`TPG_RUN_EN] = st_r.run;
        rmux[`TPG_RUN_PRE] = st_r.pre_run;
        rmux[`TPG_RUN_DBE] = st_r.dbe;
      end
      `TPG_OFS_MODE:
      begin
        rmux[`TPG_MOD_CLK_HI:`TPG_MOD_CLK_LO] = st_r.clk_sel;
        rmux[`TPG_MOD_CPM_HI:`TPG_MOD_CPM_LO] = st_r.cap_mode;
        rmux[`TPG_MOD_PGM] = st_r.pgm;
      end
      `TPG_OFS_FLOP:
      begin
        rmux[`TPG_FFC_CMD_HI:`TPG_FFC_CMD_LO] = `TPG_FFC_CMD_READ;
        rmux[`TPG_FFC_TGL_A] = st_r.ten_a;
        rmux[`TPG_FFC_TGL_B] = st_r.ten_b;
        rmux[`TPG_FFC_TGL_CAPA] = st_r.ten_cap_a;
        rmux[`TPG_FFC_TGL_CAPB] = st_r.ten_cap_b;
        rmux[`TPG_FFC_STATE] = st_r.flop;
      end
      `TPG_OFS_CMPA: rmux[`TPG_CNT_W-1:0] = st_r.cmp_a;
      `TPG_OFS_CMPB: rmux[`TPG_CNT_W-1:0] = st_r.cmp_b;
      `TPG_OFS_CAPA: rmux[`TPG_CNT_W-1:0] = st_r.cap_a;
      `TPG_OFS_CAPB: rmux[`TPG_CNT_W-1:0] = st_r.cap_b;
      `TPG_OFS_CNT: rmux[`TPG_CNT_W-1:0] = st_r.cnt;
      `TPG_OFS_STAT: rmux[`TPG_ST_OVF:`TPG_ST_MATCH_A] = st_r.status;
      default: rbad = 1'b1;
    endcase

    // Read channel bookkeeping
    if (rd_do)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rmux;
      st_nxt.rresp = rbad ? `TPG_RESP_SLVERR : `TPG_RESP_OKAY;
    end
    else if (st_r.rvalid && RREADY)
    begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************

  // Everything resets to zero: timer stopped, flop low, bus idle
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule // tpg_timer
`default_nettype wire

/* File: testbench/tpg_timer_props.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tpg_consts.svh"
// ********************
// Port checker
// ********************
module tpg_timer_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [`TPG_ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic PULSE_OUT_PIN,
  input wire logic MATCH_B_IRQ
);
  // One clock domain, so one default for every property
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped before it was taken");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped before it was taken");
  wr_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write accepted while a response is pending");
  rd_block_a: assert property (RVALID |-> !ARREADY)
    else $error("read accepted while read data is pending");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |=> BVALID)
    else $error("write answer late");
  bad_addr_a: assert property (ARVALID && ARREADY && ARADDR > 8'h23 |=>
    RRESP == 2'h2 && RDATA == 32'h0)
    else $error("unmapped read not refused");
  flop_view_a: assert property (ARVALID && ARREADY && ARADDR == 8'h08 |=>
    RDATA[6] == $past(PULSE_OUT_PIN))
    else $error("flop state read differs from pin");
  irq_pulse_a: assert property (MATCH_B_IRQ |=> !MATCH_B_IRQ)
    else $error("match interrupt longer than one cycle");
endmodule // tpg_timer_props

bind tpg_timer tpg_timer_props i_tpg_timer_props (
  .CLK(CLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
  .PULSE_OUT_PIN(PULSE_OUT_PIN), .MATCH_B_IRQ(MATCH_B_IRQ)
);
`default_nettype wire

/* File: testbench/tpg_pins_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************
// External pin sources
// ********************
module tpg_pins_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] pin_req,
  output logic event_in,
  output logic trig_a,
  output logic trig_b,
  output logic comp_flop
);
  logic [3:0] pins_r;
  // Levels follow one clock late, so edges land off the bench's own edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pins_r <= 4'h0;
    else
      pins_r <= pin_req;
  end
  // Each source drives its pin at all times
  assign event_in = pins_r[0];
  assign trig_a = pins_r[1];
  assign trig_b = pins_r[2];
  assign comp_flop = pins_r[3];
endmodule // tpg_pins_model
`default_nettype wire

/* File: testbench/tpg_timer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tpg_consts.svh"
module tpg_timer_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] pin_req = 4'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, pin, irq, ev, ta, tb, cf;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, last_rd;
  logic [31:0] rnd = 32'h0b7f;
  logic [65:0] rd_q[$];
  logic [1:0] b_q[$];
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  int irq_n = 0;
  // ********************
  // Design, pin sources and clock
  // ********************
  tpg_timer i_tpg_timer (
    .CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .EVENT_IN(ev), .TRIGGER_IN_A(ta), .TRIGGER_IN_B(tb), .COMPANION_TIMER_FLOP(cf),
    .PULSE_OUT_PIN(pin), .MATCH_B_IRQ(irq)
  );
  tpg_pins_model i_tpg_pins_model (
    .clk(clk), .rst_n(rst_n), .pin_req(pin_req), .event_in(ev), .trig_a(ta),
    .trig_b(tb), .comp_flop(cf)
  );
  // 20 MHz clock
  always #25 clk = ~clk;
  // ********************
  // Checking and bus tasks
  // ********************
  task automatic end_sim();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic chk_rd(input logic [65:0] e);
    chk_val({30'h0, rresp}, {30'h0, e[65:64]}, "read response");
    chk_val(rdata & e[63:32], e[31:0] & e[63:32], "read data");
  endtask
  task automatic chk_b(input logic [1:0] e);
    chk_val({30'h0, bresp}, {30'h0, e}, "write response");
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_q.push_back(er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (!aw_ok && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid)
      @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                        input logic [1:0] er);
    rd_q.push_back({er, m, e});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    last_rd = rdata;
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, 2'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    axi_rd(a, e, m, 2'h0);
  endtask
  // Counts lengths of runs at one level on the output pin
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (pin !== lvl)
      @(posedge clk);
    while (pin === lvl)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // Watcher: compares each answer with the oldest note; also cuts a hang
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (irq === 1'b1)
      irq_n <= irq_n + 1;
    if (rvalid && rready)
      chk_rd(rd_q.pop_front());
    if (bvalid && bready)
      chk_b(b_q.pop_front());
    if (cycles == 30000)
    begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end
  // ********************
  // Main sequence
  // ********************
  initial
  begin
    int hi;
    int lo;
    int gap;
    logic [15:0] ca;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd(8'(4 * i), (i == 2) ? 32'h3 : 32'h0, 32'hffffffff);
    axi_rd(8'h40, 32'h0, 32'hffffffff, 2'h2);
    axi_wr(8'h40, 32'h5, 2'h2);
    wr(`TPG_OFS_CNT, 32'h1234);
    rd(`TPG_OFS_CNT, 32'h0, 32'hffffffff);
    // Random compare values, upper half must read back zero
    for (int i = 0; i < 2; i++)
    begin
      rnd = lfsr(rnd);
      wr(i ? `TPG_OFS_CMPB : `TPG_OFS_CMPA, rnd);
      rd(i ? `TPG_OFS_CMPB : `TPG_OFS_CMPA, {16'h0, rnd[15:0]}, 32'hffffffff);
    end
    // Lane 0 only: the high byte of compare B must survive
    wstrb <= 4'h1;
    wr(`TPG_OFS_CMPB, 32'h0);
    wstrb <= 4'hf;
    rd(`TPG_OFS_CMPB, {16'h0, rnd[15:8], 8'h00}, 32'hffffffff);
    // Square wave with both polarities: compare A 3, compare B 9 (period 10 counts), clock by 2
    wr(`TPG_OFS_CMPA, 32'h3);
    wr(`TPG_OFS_CMPB, 32'h9);
    wr(`TPG_OFS_MODE, 32'h11);
    for (int p = 0; p < 2; p++)
    begin
      wr(`TPG_OFS_RUN, 32'h0);
      wr(`TPG_OFS_FLOP, p ? 32'hd : 32'he);
      wr(`TPG_OFS_RUN, 32'h5);
      run_len(1'b1, hi);
      run_len(1'b0, lo);
      run_len(1'b1, hi);
      chk_val(32'(hi), p ? 32'd8 : 32'd12, "high time");
      chk_val(32'(lo), p ? 32'd12 : 32'd8, "low time");
    end
    hi = irq_n;
    repeat (100) @(posedge clk);
    chk_val(32'(irq_n - hi), 32'd5, "interrupt count");
    wr(`TPG_OFS_RUN, 32'h0);
    rd(`TPG_OFS_STAT, 32'h3, 32'h7);
    rd(`TPG_OFS_STAT, 32'h0, 32'h7);
    // Double-buffered duty: writes wait for the period match
    wr(`TPG_OFS_RUN, 32'h80);
    wr(`TPG_OFS_CMPA, 32'h5);
    rd(`TPG_OFS_CMPA, 32'h3, 32'hffffffff);
    wr(`TPG_OFS_RUN, 32'h85);
    repeat (30) @(posedge clk);
    rd(`TPG_OFS_CMPA, 32'h5, 32'hffffffff);
    wr(`TPG_OFS_CMPA, 32'h7);
    repeat (30) @(posedge clk);
    rd(`TPG_OFS_CMPA, 32'h7, 32'hffffffff);
    // Capture modes: off, two pins, width, companion flop
    for (int m = 0; m < 4; m++)
    begin
      gap = 20 + 10 * m;
      wr(`TPG_OFS_RUN, 32'h0);
      wr(`TPG_OFS_MODE, 32'(4 * m + 1));
      wr(`TPG_OFS_RUN, 32'h5);
      repeat (10) @(posedge clk);
      pin_req[(m == 3) ? 3 : 1] <= 1'b1;
      repeat (gap) @(posedge clk);
      pin_req[(m == 1) ? 2 : ((m == 3) ? 3 : 1)] <= (m == 1);
      repeat (10) @(posedge clk);
      rd(`TPG_OFS_CAPA, 32'h0, m ? 32'h0 : 32'hffffffff);
      ca = last_rd[15:0];
      rd(`TPG_OFS_CAPB, 32'h0, m ? 32'h0 : 32'hffffffff);
      if (m != 0)
        chk_val(32'(last_rd[15:0] - ca), 32'(gap / 2), "capture gap");
      pin_req <= 4'h0;
      repeat (10) @(posedge clk);
    end
    // Event counting keeps the prescaler bit on
    wr(`TPG_OFS_RUN, 32'h0);
    wr(`TPG_OFS_MODE, 32'h0);
    wr(`TPG_OFS_RUN, 32'h5);
    rnd = lfsr(rnd);
    repeat (3 + rnd[2:0])
    begin
      pin_req[0] <= 1'b1;
      repeat (6) @(posedge clk);
      pin_req[0] <= 1'b0;
      repeat (6) @(posedge clk);
    end
    repeat (10) @(posedge clk);
    rd(`TPG_OFS_CNT, 32'(3 + rnd[2:0]), 32'hffffffff);
    // Toggle on software capture, match toggles off
    wr(`TPG_OFS_RUN, 32'h0);
    wr(`TPG_OFS_FLOP, 32'h12);
    wr(`TPG_OFS_MODE, 32'h20);
    repeat (2) @(posedge clk);
    chk_val({31'h0, pin}, 32'h1, "capture toggle");
    rd(`TPG_OFS_FLOP, 32'h40, 32'h40);
    end_sim();
  end
endmodule // tpg_timer_tb
`default_nettype wire
